// *** dv/serial_ptp_partner.sv ***
// Far-side serial station on the half-duplex pair
`timescale 1ns/1ps
`default_nettype none
module serial_ptp_partner #(
  parameter int DIV = 32'h43e
) (
  // Clock
  input wire logic clk,
  // Pair
  input wire logic line_tx,
  input wire logic line_oe,
  output logic line_rx
);
  logic drive = 1'b1;
  logic [7:0] got = 8'h00;
  int n_got = 0;
  // Bias holds the pair high when nobody drives
  assign line_rx = line_oe ? line_tx : drive;
  // Sample device characters mid-bit, LSB first
  always begin
    @(posedge clk iff (line_oe && !line_tx));
    repeat (DIV / 2) @(posedge clk);
    repeat (8) begin
      repeat (DIV) @(posedge clk);
      got = {line_tx, got[7:1]};
    end
    repeat (DIV) @(posedge clk);
    n_got++;
  end
  // Send one 8-bit character, deferring to the device
  task automatic send_char(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (line_oe) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      drive <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask : send_char
endmodule : serial_ptp_partner
`default_nettype wire

// *** dv/serial_ptp_protocol_framer_monitor.sv ***
// Port checker for the serial framer
`timescale 1ns/1ps
`default_nettype none
module serial_ptp_protocol_framer_monitor #(
  parameter int ACK_WAIT_CYCLES = 32'h4e20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Watched ports
  input wire serial_ptp_pkg::cfg_s CONFIG,
  input wire logic RECV_VALID,
  input wire serial_ptp_pkg::byte_s RECV_WORD,
  input wire logic RECV_READY,
  input wire logic [7:0] CALL_RETURN_STATUS,
  input wire logic LINE_TX,
  input wire logic LINE_TX_OE
);
  logic [31:0] run_ff;
  logic [31:0] char_len;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Clocks per character
  always_comb begin
    char_len = 32'(CONFIG.bit_div < serial_ptp_pkg::MIN_BIT_DIV ?
      serial_ptp_pkg::MIN_BIT_DIV : CONFIG.bit_div) *
      (CONFIG.width == 2'h0 ? 32'h8 : CONFIG.width == 2'h1 ? 32'h9 : 32'ha);
  end
  // Length of the current drive run
  always_ff @(posedge CLK) begin
    run_ff <= (!RST_N || !LINE_TX_OE) ? 32'h0 : run_ff + 32'h1;
  end
  sequence tx_start; $rose(LINE_TX_OE); endsequence
  sequence start_low; !LINE_TX [*8]; endsequence
  AST_IDLE_HIGH: assert property (!LINE_TX_OE |-> LINE_TX)
    else $error("line not idle high");
  AST_START_LOW: assert property (tx_start |-> start_low)
    else $error("start bit missing");
  AST_CHAR_LEN: assert property ($fell(LINE_TX_OE) |->
    run_ff % char_len == 32'h0) else $error("drive run length wrong");
  AST_STOP_HIGH: assert property ($fell(LINE_TX_OE) |->
    $past(LINE_TX)) else $error("stop bit missing");
  AST_BUSY_TX: assert property (tx_start |->
    CALL_RETURN_STATUS[serial_ptp_pkg::ST_BUSY]) else $error("busy not set");
  AST_NO_ACK: assert property (CONFIG.mode inside
    {serial_ptp_pkg::M_ASCII, serial_ptp_pkg::M_STXETX} |->
    !CALL_RETURN_STATUS[serial_ptp_pkg::ST_ACK_WAIT]) else $error("ack wait");
  AST_RECV_HOLD: assert property (RECV_VALID && !RECV_READY |=>
    RECV_VALID && $stable(RECV_WORD)) else $error("receive word lost");
  AST_ASCII_LAST: assert property (RECV_VALID &&
    CONFIG.mode == serial_ptp_pkg::M_ASCII |-> RECV_WORD.last)
    else $error("ascii byte not released alone");
endmodule : serial_ptp_protocol_framer_monitor
bind serial_ptp_protocol_framer serial_ptp_protocol_framer_monitor #(
  .ACK_WAIT_CYCLES(ACK_WAIT_CYCLES)
) mon (.CLK(CLK), .RST_N(RST_N), .CONFIG(CONFIG), .RECV_VALID(RECV_VALID),
  .RECV_WORD(RECV_WORD), .RECV_READY(RECV_READY),
  .CALL_RETURN_STATUS(CALL_RETURN_STATUS), .LINE_TX(LINE_TX),
  .LINE_TX_OE(LINE_TX_OE));
`default_nettype wire

// *** dv/tb_serial_ptp_protocol_framer.sv ***
// Self-checking bench for the serial framer
`timescale 1ns/1ps
`default_nettype none
module tb_serial_ptp_protocol_framer;
  typedef struct packed {
    logic rx;
    logic [7:0] data;
    logic [7:0] exp;
  } row_s;
  localparam int LIMIT = 95000;
  localparam row_s ROWS [2] = '{'{1'b0, 8'ha5, 8'ha5}, '{1'b1, 8'h3c, 8'h3c}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  serial_ptp_pkg::cfg_s cfg = '{serial_ptp_pkg::M_ASCII, 2'h2, 8'hff, 8'hff,
    8'hff, 8'hff, 16'h043e, 16'h0000};
  logic send_valid = 1'b0;
  serial_ptp_pkg::byte_s send_word = '0;
  logic recv_ready = 1'b0;
  logic send_ready, recv_valid, line_rx, line_tx, line_oe;
  serial_ptp_pkg::byte_s recv_word;
  logic [7:0] status;
  int n_errors = 0, checks = 0, cyc = 0, n = 0;
  always #4 clk = ~clk;
  serial_ptp_protocol_framer #(.ACK_WAIT_CYCLES(32'h9c40)) dut (
    .CLK(clk), .RST_N(rst_n), .CONFIG(cfg), .SEND_VALID(send_valid),
    .SEND_WORD(send_word), .SEND_READY(send_ready), .RECV_VALID(recv_valid),
    .RECV_WORD(recv_word), .RECV_READY(recv_ready),
    .CALL_RETURN_STATUS(status), .LINE_RX(line_rx), .LINE_TX(line_tx),
    .LINE_TX_OE(line_oe));
  serial_ptp_partner partner (.clk(clk), .line_tx(line_tx), .line_oe(line_oe),
    .line_rx(line_rx));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Queue one single-byte frame
  task automatic push(input logic [7:0] d);
    send_valid <= 1'b1;
    send_word <= {1'b1, d};
    do @(posedge clk); while (send_ready !== 1'b1);
    send_valid <= 1'b0;
  endtask : push
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    check({send_ready, recv_valid, line_tx, line_oe, 4'h0, status},
      16'h2000);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({15'h0, send_ready}, 16'h0001);
    foreach (ROWS[i]) begin
      n = partner.n_got;
      if (ROWS[i].rx) begin
        partner.send_char(ROWS[i].data);
        do @(posedge clk); while (recv_valid !== 1'b1);
        check({recv_word, 7'h0}, {1'b1, ROWS[i].exp, 7'h0});
        recv_ready <= 1'b1;
        @(posedge clk);
        recv_ready <= 1'b0;
      end else begin
        push(ROWS[i].data);
        while (partner.n_got == n) @(posedge clk);
        check({8'h0, partner.got}, {8'h0, ROWS[i].exp});
      end
    end
    // Framed receive with controller stalling
    cfg.mode <= serial_ptp_pkg::M_STXETX;
    cfg.sid1 <= 8'h02;
    cfg.eid1 <= 8'h03;
    recv_ready <= 1'b0;
    partner.send_char(8'h02);
    partner.send_char(8'h41);
    @(posedge clk);
    check({15'h0, recv_valid}, 16'h0000);
    partner.send_char(8'h03);
    do @(posedge clk); while (recv_valid !== 1'b1);
    repeat (4) @(posedge clk);
    check({recv_valid, recv_word, 6'h0}, {2'h3, 8'h41, 6'h0});
    check({15'h0, status[serial_ptp_pkg::ST_ERR_FRAME]},
      16'h0000);
    recv_ready <= 1'b1;
    repeat (2) @(posedge clk);
    check({15'h0, recv_valid}, 16'h0000);
    // Modbus request, reply fetched by the controller
    cfg.mode <= serial_ptp_pkg::M_MODBUS;
    cfg.idle_to <= 16'h1000;
    n = partner.n_got;
    push(8'h11);
    while (partner.n_got == n) @(posedge clk);
    check({8'h0, status}, 16'h0003);
    partner.send_char(8'h22);
    do @(posedge clk); while (recv_valid !== 1'b1);
    check({recv_word, 7'h0}, {1'b1, 8'h22, 7'h0});
    check({8'h0, status}, 16'h0004);
    // Fill the send buffer until it refuses
    cfg.mode <= serial_ptp_pkg::M_ASCII;
    send_valid <= 1'b1;
    send_word <= {1'b1, 8'h55};
    n = 0;
    repeat (2100) begin
      @(posedge clk);
      if (send_ready === 1'b1) n++;
    end
    send_valid <= 1'b0;
    check({15'h0, n == serial_ptp_pkg::FIFO_DEPTH ||
      n == serial_ptp_pkg::FIFO_DEPTH + 1}, 16'h0001);
    // Reset in mid-transmission
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({send_ready, recv_valid, line_tx, line_oe, 4'h0, status},
      16'h2000);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({15'h0, send_ready}, 16'h0001);
    report_and_stop();
  end
endmodule : tb_serial_ptp_protocol_framer
`default_nettype wire

// *** rtl/serial_ptp_pkg.sv ***
// Shared constants and types for the serial point-to-point framer
`default_nettype none
package serial_ptp_pkg;
  // Clock and line timing
  localparam int CLK_KHZ = 125000;
  localparam int MAX_BAUD = 115200;
  localparam logic [15:0] MIN_BIT_DIV =
    16'((CLK_KHZ * 1000 + MAX_BAUD - 1) / MAX_BAUD);
  localparam int ACK_WAIT_MS = 500;
  localparam int ACK_WAIT_CYC = ACK_WAIT_MS * CLK_KHZ;
  // Buffers: two 1024-byte halves each
  localparam int FIFO_HALF = 1024;
  localparam int FIFO_DEPTH = 2 * FIFO_HALF;
  localparam logic [11:0] FIFO_FULL = 12'h800;
  // Control characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_DLE = 8'h10;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] ID_MIN = 8'h01;
  localparam logic [7:0] ID_MAX = 8'h1f;
  localparam logic [7:0] ID_UNUSED = 8'hff;
  localparam logic [7:0] PAY_MIN = 8'h20;
  localparam logic [7:0] PAY_MAX6 = 8'h3f;
  localparam logic [7:0] PAY_MAX7 = 8'h7f;
  localparam logic [7:0] PAY_MAX8 = 8'hff;
  localparam logic [7:0] USS_LGE = 8'h0c;
  localparam int USS_BCAST_BIT = 5;
  // Reset values
  localparam logic [1:0] RST_USS_SKIP = 2'd2;
  localparam logic LINE_IDLE = 1'b1;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_ACK_WAIT = 1;
  localparam int ST_ACK_OK = 2;
  localparam int ST_ERR_FRAME = 3;
  localparam int ST_ERR_BCC = 4;
  localparam int ST_ERR_TIMEOUT = 5;
  localparam int ST_ERR_NAK = 6;
  localparam int ST_OVERFLOW = 7;

  typedef enum logic [2:0] {
    M_ASCII, M_STXETX, M_3964R, M_USS, M_MODBUS
  } mode_e;
  typedef enum logic [2:0] {
    T_IDLE, T_HDR, T_LEN, T_DATA, T_DLE2, T_TRL, T_WAIT
  } tx_e;
  typedef enum logic [2:0] {
    R_HUNT, R_ST2, R_BODY, R_END2, R_DLE, R_BCC
  } rx_e;

  typedef struct packed {
    mode_e mode;
    logic [1:0] width;
    logic [7:0] sid1;
    logic [7:0] sid2;
    logic [7:0] eid1;
    logic [7:0] eid2;
    logic [15:0] bit_div;
    logic [15:0] idle_to;
  } cfg_s;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } byte_s;
endpackage : serial_ptp_pkg
`default_nettype wire

// *** rtl/serial_ptp_protocol_framer.sv ***
// Serial point-to-point protocol framer with send and receive buffers
`timescale 1ns/1ps
`default_nettype none

module serial_ptp_protocol_framer #(
  parameter int ACK_WAIT_CYCLES = serial_ptp_pkg::ACK_WAIT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Configuration
  input wire serial_ptp_pkg::cfg_s CONFIG,
  // Send stream from controller
  input wire logic SEND_VALID,
  input wire serial_ptp_pkg::byte_s SEND_WORD,
  output logic SEND_READY,
  // Receive stream to controller
  output logic RECV_VALID,
  output serial_ptp_pkg::byte_s RECV_WORD,
  input wire logic RECV_READY,
  // Call return status
  output logic [7:0] CALL_RETURN_STATUS,
  // Half-duplex line
  input wire logic LINE_RX,
  output logic LINE_TX,
  output logic LINE_TX_OE
);

  typedef struct packed {
    serial_ptp_pkg::tx_e ts;
    logic [1:0] idx;
    logic hs;
    logic first;
    logic bc;
    logic [7:0] tbcc;
    logic [31:0] wcnt;
    logic [serial_ptp_pkg::FIFO_DEPTH-1:0][8:0] smem;
    logic [11:0] swr;
    logic [11:0] srd;
    logic [11:0] sfr;
    logic sready;
    logic tbusy;
    logic [11:0] tsh;
    logic [3:0] tbit;
    logic [15:0] tdiv;
    logic r1;
    logic r2;
    logic rbusy;
    logic [3:0] rbit;
    logic [15:0] rdiv;
    logic [7:0] rsh;
    logic revt;
    logic [7:0] rbyte;
    logic rferr;
    serial_ptp_pkg::rx_e rs;
    logic [7:0] rbcc;
    logic [1:0] skip;
    logic [15:0] icnt;
    logic ctlp;
    logic [7:0] ctlb;
    logic [serial_ptp_pkg::FIFO_DEPTH-1:0][8:0] rmem;
    logic [11:0] rwr;
    logic [11:0] rcm;
    logic [11:0] rrd;
    logic [1:0][8:0] sk;
    logic [1:0] skn;
    logic rv;
    logic [7:0] stat;
  } st_s;

  st_s s_ff;
  st_s nxt_s;

  // Identifier usable only inside 01h..1Fh
  function automatic logic id_ok(input logic [7:0] b);
    id_ok = (b >= serial_ptp_pkg::ID_MIN) && (b <= serial_ptp_pkg::ID_MAX);
  endfunction : id_ok

  // Data bits per character; 5-bit width is not offered
  function automatic logic [3:0] nbits(input logic [1:0] w);
    nbits = (w == 2'd3) ? 4'd8 : 4'd6 + {2'b00, w};
  endfunction : nbits

  // Highest payload character for the width
  function automatic logic [7:0] pay_max(input logic [1:0] w);
    if (w == 2'd0) begin
      pay_max = serial_ptp_pkg::PAY_MAX6;
    end else if (w == 2'd1) begin
      pay_max = serial_ptp_pkg::PAY_MAX7;
    end else begin
      pay_max = serial_ptp_pkg::PAY_MAX8;
    end
  endfunction : pay_max

  // Next-state logic for the whole block
  always_comb begin
    logic tgo, push, commit, drop, fin, done, fire, drain, take;
    logic [7:0] tb, pb, c;
    logic [15:0] bd;
    logic [3:0] nb;
    logic [1:0] cnt;
    logic [11:0] w;
    serial_ptp_pkg::byte_s e;
    nxt_s = s_ff;
    tgo = 1'b0;
    push = 1'b0;
    commit = 1'b0;
    drop = 1'b0;
    fin = 1'b0;
    done = 1'b0;
    fire = 1'b0;
    drain = 1'b0;
    take = 1'b0;
    tb = 8'h00;
    pb = 8'h00;
    c = s_ff.rbyte;
    cnt = 2'd0;
    w = 12'h000;
    e = s_ff.smem[s_ff.srd[10:0]];
    nb = nbits(CONFIG.width);
    bd = (CONFIG.bit_div < serial_ptp_pkg::MIN_BIT_DIV) ?
         serial_ptp_pkg::MIN_BIT_DIV : CONFIG.bit_div;
    nxt_s.revt = 1'b0;

    // Send FIFO fill from the controller
    if (SEND_VALID && s_ff.sready) begin
      nxt_s.smem[s_ff.swr[10:0]] = SEND_WORD;
      nxt_s.swr = s_ff.swr + 12'h001;
    end

    // Transmit framing engine
    case (s_ff.ts)
      serial_ptp_pkg::T_IDLE: begin
        if (!s_ff.tbusy && s_ff.ctlp) begin
          tgo = 1'b1;
          tb = s_ff.ctlb;
          nxt_s.ctlp = 1'b0;
          nxt_s.stat[serial_ptp_pkg::ST_BUSY] = 1'b1;
        end else if (!s_ff.tbusy && s_ff.sfr != 12'h000) begin
          nxt_s.stat = 8'h00;
          nxt_s.stat[serial_ptp_pkg::ST_BUSY] = 1'b1;
          nxt_s.tbcc = 8'h00;
          nxt_s.idx = 2'd0;
          nxt_s.hs = 1'b0;
          nxt_s.first = 1'b1;
          nxt_s.bc = 1'b0;
          nxt_s.wcnt = 32'(ACK_WAIT_CYCLES);
          case (CONFIG.mode)
            serial_ptp_pkg::M_STXETX: nxt_s.ts = serial_ptp_pkg::T_HDR;
            serial_ptp_pkg::M_3964R: begin
              tgo = 1'b1;
              tb = serial_ptp_pkg::CH_STX;
              nxt_s.ts = serial_ptp_pkg::T_WAIT;
            end
            serial_ptp_pkg::M_USS: begin
              tgo = 1'b1;
              tb = serial_ptp_pkg::CH_STX;
              nxt_s.ts = serial_ptp_pkg::T_LEN;
            end
            default: nxt_s.ts = serial_ptp_pkg::T_DATA;
          endcase
        end
      end
      serial_ptp_pkg::T_HDR: begin
        if (!s_ff.tbusy) begin
          tb = (s_ff.idx == 2'd0) ? CONFIG.sid1 : CONFIG.sid2;
          tgo = id_ok(tb);
          nxt_s.idx = s_ff.idx + 2'd1;
          if (s_ff.idx != 2'd0) begin
            nxt_s.ts = serial_ptp_pkg::T_DATA;
          end
        end
      end
      serial_ptp_pkg::T_LEN: begin
        if (!s_ff.tbusy) begin
          tgo = 1'b1;
          tb = serial_ptp_pkg::USS_LGE;
          nxt_s.ts = serial_ptp_pkg::T_DATA;
        end
      end
      serial_ptp_pkg::T_DATA: begin
        if (!s_ff.tbusy && s_ff.srd != s_ff.swr) begin
          tgo = 1'b1;
          tb = e.data;
          nxt_s.srd = s_ff.srd + 12'h001;
          nxt_s.idx = {1'b0, e.last};
          nxt_s.first = 1'b0;
          if (s_ff.first && CONFIG.mode == serial_ptp_pkg::M_USS) begin
            nxt_s.bc = e.data[serial_ptp_pkg::USS_BCAST_BIT];
          end
          if (CONFIG.mode == serial_ptp_pkg::M_3964R &&
              e.data == serial_ptp_pkg::CH_DLE) begin
            nxt_s.ts = serial_ptp_pkg::T_DLE2;
          end else begin
            fin = e.last;
          end
        end
      end
      serial_ptp_pkg::T_DLE2: begin
        if (!s_ff.tbusy) begin
          tgo = 1'b1;
          tb = serial_ptp_pkg::CH_DLE;
          nxt_s.ts = serial_ptp_pkg::T_DATA;
          fin = s_ff.idx[0];
        end
      end
      serial_ptp_pkg::T_TRL: begin
        if (!s_ff.tbusy) begin
          nxt_s.idx = s_ff.idx + 2'd1;
          case (CONFIG.mode)
            serial_ptp_pkg::M_STXETX: begin
              tb = (s_ff.idx == 2'd0) ? CONFIG.eid1 : CONFIG.eid2;
              tgo = id_ok(tb);
              done = (s_ff.idx != 2'd0);
            end
            serial_ptp_pkg::M_3964R: begin
              tgo = 1'b1;
              tb = (s_ff.idx == 2'd0) ? serial_ptp_pkg::CH_DLE :
                   (s_ff.idx == 2'd1) ? serial_ptp_pkg::CH_ETX : s_ff.tbcc;
              if (s_ff.idx == 2'd2) begin
                nxt_s.hs = 1'b1;
                nxt_s.ts = serial_ptp_pkg::T_WAIT;
              end
            end
            default: begin
              tgo = 1'b1;
              tb = s_ff.tbcc;
              nxt_s.hs = 1'b1;
              nxt_s.ts = serial_ptp_pkg::T_WAIT;
              done = s_ff.bc;
            end
          endcase
        end
      end
      serial_ptp_pkg::T_WAIT: begin
        nxt_s.stat[serial_ptp_pkg::ST_ACK_WAIT] = 1'b1;
        nxt_s.wcnt = s_ff.wcnt - 32'h1;
        if (s_ff.wcnt == 32'h0) begin
          nxt_s.stat[serial_ptp_pkg::ST_ERR_TIMEOUT] = 1'b1;
          done = 1'b1;
        end else if (CONFIG.mode == serial_ptp_pkg::M_3964R) begin
          if (s_ff.revt && s_ff.rbyte == serial_ptp_pkg::CH_DLE) begin
            if (s_ff.hs) begin
              nxt_s.stat[serial_ptp_pkg::ST_ACK_OK] = 1'b1;
              done = 1'b1;
            end else begin
              nxt_s.tbcc = 8'h00;
              nxt_s.ts = serial_ptp_pkg::T_DATA;
            end
          end else if (s_ff.revt && !(!s_ff.hs &&
                       s_ff.rbyte == serial_ptp_pkg::CH_STX)) begin
            nxt_s.stat[serial_ptp_pkg::ST_ERR_NAK] = 1'b1;
            done = 1'b1;
          end
        end
      end
      default: nxt_s.ts = serial_ptp_pkg::T_IDLE;
    endcase

    // End of payload: trailer, ack wait or finish
    if (fin) begin
      nxt_s.idx = (CONFIG.mode == serial_ptp_pkg::M_USS) ? 2'd2 : 2'd0;
      case (CONFIG.mode)
        serial_ptp_pkg::M_STXETX, serial_ptp_pkg::M_3964R,
        serial_ptp_pkg::M_USS: nxt_s.ts = serial_ptp_pkg::T_TRL;
        serial_ptp_pkg::M_MODBUS: nxt_s.ts = serial_ptp_pkg::T_WAIT;
        default: done = 1'b1;
      endcase
    end
    if (tgo) begin
      nxt_s.tbcc = nxt_s.tbcc ^ tb;
    end

    // Send FIFO accounting
    nxt_s.sfr = s_ff.sfr + {11'h000, SEND_VALID && s_ff.sready &&
                SEND_WORD.last} - {11'h000, nxt_s.srd != s_ff.srd && e.last};
    nxt_s.sready = (nxt_s.swr - nxt_s.srd) != serial_ptp_pkg::FIFO_FULL;

    // Character transmitter; drives the pair only while shifting
    if (tgo) begin
      nxt_s.tbusy = 1'b1;
      nxt_s.tsh = {3'b111, tb & (8'hff >> (4'd8 - nb)), 1'b0} |
                  (12'hfff << (nb + 4'd1));
      nxt_s.tbit = 4'd0;
      nxt_s.tdiv = bd - 16'h1;
    end else if (s_ff.tbusy) begin
      if (s_ff.tdiv != 16'h0) begin
        nxt_s.tdiv = s_ff.tdiv - 16'h1;
      end else begin
        nxt_s.tdiv = bd - 16'h1;
        nxt_s.tsh = {1'b1, s_ff.tsh[11:1]};
        nxt_s.tbit = s_ff.tbit + 4'd1;
        nxt_s.tbusy = (s_ff.tbit != nb + 4'd1);
      end
    end

    // Line synchroniser and character receiver, deaf while sending
    nxt_s.r1 = LINE_RX;
    nxt_s.r2 = s_ff.r1;
    if (!s_ff.rbusy) begin
      if (!s_ff.r2 && !s_ff.tbusy) begin
        nxt_s.rbusy = 1'b1;
        nxt_s.rdiv = {1'b0, bd[15:1]};
        nxt_s.rbit = 4'd0;
      end
    end else if (s_ff.rdiv != 16'h0) begin
      nxt_s.rdiv = s_ff.rdiv - 16'h1;
    end else begin
      nxt_s.rdiv = bd - 16'h1;
      nxt_s.rbit = s_ff.rbit + 4'd1;
      if (s_ff.rbit == 4'd0) begin
        nxt_s.rbusy = !s_ff.r2;
      end else if (s_ff.rbit <= nb) begin
        nxt_s.rsh = {s_ff.r2, s_ff.rsh[7:1]};
      end else begin
        nxt_s.rbusy = 1'b0;
        nxt_s.revt = 1'b1;
        nxt_s.rbyte = s_ff.rsh >> (4'd8 - nb);
        nxt_s.rferr = !s_ff.r2;
      end
    end

    // Inter-character timer
    if (s_ff.revt) begin
      nxt_s.icnt = CONFIG.idle_to;
    end else if (s_ff.icnt != 16'h0) begin
      nxt_s.icnt = s_ff.icnt - 16'h1;
      fire = (s_ff.icnt == 16'h1);
    end

    // Receive unframing per procedure
    if (s_ff.revt) begin
      if (s_ff.rferr) begin
        nxt_s.stat[serial_ptp_pkg::ST_ERR_FRAME] = 1'b1;
      end
      case (CONFIG.mode)
        serial_ptp_pkg::M_ASCII: begin
          push = 1'b1;
          pb = c;
          commit = 1'b1;
        end
        serial_ptp_pkg::M_STXETX: begin
          if (s_ff.rs == serial_ptp_pkg::R_ST2) begin
            nxt_s.rs = (c == CONFIG.sid2) ? serial_ptp_pkg::R_BODY :
                       serial_ptp_pkg::R_HUNT;
          end else if (s_ff.rs == serial_ptp_pkg::R_END2) begin
            nxt_s.rs = serial_ptp_pkg::R_HUNT;
            commit = (c == CONFIG.eid2);
            drop = !commit;
            nxt_s.stat[serial_ptp_pkg::ST_ERR_FRAME] = !commit ||
              nxt_s.stat[serial_ptp_pkg::ST_ERR_FRAME];
          end else if (s_ff.rs == serial_ptp_pkg::R_HUNT &&
                       id_ok(CONFIG.sid1)) begin
            drop = 1'b1;
            if (c == CONFIG.sid1) begin
              nxt_s.rs = id_ok(CONFIG.sid2) ? serial_ptp_pkg::R_ST2 :
                         serial_ptp_pkg::R_BODY;
            end
          end else if (id_ok(CONFIG.eid1) && c == CONFIG.eid1) begin
            nxt_s.rs = id_ok(CONFIG.eid2) ? serial_ptp_pkg::R_END2 :
                       serial_ptp_pkg::R_HUNT;
            commit = !id_ok(CONFIG.eid2);
          end else begin
            push = 1'b1;
            pb = c;
            nxt_s.rs = serial_ptp_pkg::R_BODY;
            if (c < serial_ptp_pkg::PAY_MIN || c > pay_max(CONFIG.width)) begin
              nxt_s.stat[serial_ptp_pkg::ST_ERR_FRAME] = 1'b1;
            end
          end
        end
        serial_ptp_pkg::M_3964R: begin
          nxt_s.rbcc = s_ff.rbcc ^ c;
          case (s_ff.rs)
            serial_ptp_pkg::R_BODY: begin
              push = (c != serial_ptp_pkg::CH_DLE);
              pb = c;
              if (!push) begin
                nxt_s.rs = serial_ptp_pkg::R_DLE;
              end
            end
            serial_ptp_pkg::R_DLE: begin
              if (c == serial_ptp_pkg::CH_DLE) begin
                push = 1'b1;
                pb = c;
                nxt_s.rs = serial_ptp_pkg::R_BODY;
              end else if (c == serial_ptp_pkg::CH_ETX) begin
                nxt_s.rs = serial_ptp_pkg::R_BCC;
              end else begin
                drop = 1'b1;
                nxt_s.ctlp = 1'b1;
                nxt_s.ctlb = serial_ptp_pkg::CH_NAK;
                nxt_s.stat[serial_ptp_pkg::ST_ERR_FRAME] = 1'b1;
                nxt_s.rs = serial_ptp_pkg::R_HUNT;
              end
            end
            serial_ptp_pkg::R_BCC: begin
              commit = (c == s_ff.rbcc);
              drop = !commit;
              nxt_s.ctlp = 1'b1;
              nxt_s.ctlb = commit ? serial_ptp_pkg::CH_DLE :
                           serial_ptp_pkg::CH_NAK;
              nxt_s.stat[serial_ptp_pkg::ST_ERR_BCC] = !commit ||
                nxt_s.stat[serial_ptp_pkg::ST_ERR_BCC];
              nxt_s.rs = serial_ptp_pkg::R_HUNT;
            end
            default: begin
              if (c == serial_ptp_pkg::CH_STX &&
                  !(s_ff.ts == serial_ptp_pkg::T_WAIT && !s_ff.hs)) begin
                drop = 1'b1;
                nxt_s.ctlp = 1'b1;
                nxt_s.ctlb = serial_ptp_pkg::CH_DLE;
                nxt_s.rbcc = 8'h00;
                nxt_s.rs = serial_ptp_pkg::R_BODY;
              end
            end
          endcase
        end
        default: begin
          nxt_s.rbcc = s_ff.rbcc ^ c;
          if (CONFIG.mode == serial_ptp_pkg::M_USS && s_ff.skip != 2'd0) begin
            nxt_s.skip = s_ff.skip - 2'd1;
          end else begin
            push = 1'b1;
            pb = c;
          end
        end
      endcase
    end

    // Line fell silent: release or discard collected characters
    if (fire) begin
      case (CONFIG.mode)
        serial_ptp_pkg::M_STXETX: begin
          if (!id_ok(CONFIG.eid1) && s_ff.rs == serial_ptp_pkg::R_BODY) begin
            commit = 1'b1;
            nxt_s.rs = serial_ptp_pkg::R_HUNT;
          end
        end
        serial_ptp_pkg::M_3964R: begin
          drop = (s_ff.rs != serial_ptp_pkg::R_HUNT);
          nxt_s.rs = serial_ptp_pkg::R_HUNT;
        end
        serial_ptp_pkg::M_ASCII: ;
        default: begin
          commit = 1'b1;
          nxt_s.skip = serial_ptp_pkg::RST_USS_SKIP;
          nxt_s.rbcc = 8'h00;
          if (s_ff.ts == serial_ptp_pkg::T_WAIT) begin
            nxt_s.stat[serial_ptp_pkg::ST_ACK_OK] = 1'b1;
            done = 1'b1;
          end
          if (CONFIG.mode == serial_ptp_pkg::M_USS && s_ff.rbcc != 8'h00) begin
            nxt_s.stat[serial_ptp_pkg::ST_ERR_BCC] = 1'b1;
          end
        end
      endcase
    end
    if (done) begin
      nxt_s.ts = serial_ptp_pkg::T_IDLE;
      nxt_s.stat[serial_ptp_pkg::ST_ACK_WAIT] = 1'b0;
    end
    // Busy until the last character has left the line
    if (nxt_s.ts == serial_ptp_pkg::T_IDLE && !nxt_s.tbusy) begin
      nxt_s.stat[serial_ptp_pkg::ST_BUSY] = 1'b0;
    end

    // Receive FIFO: uncommitted tail, committed region visible
    if (drop) begin
      nxt_s.rwr = s_ff.rcm;
    end
    if (push) begin
      if ((nxt_s.rwr - s_ff.rrd) == serial_ptp_pkg::FIFO_FULL) begin
        nxt_s.stat[serial_ptp_pkg::ST_OVERFLOW] = 1'b1;
      end else begin
        nxt_s.rmem[nxt_s.rwr[10:0]] = {1'b0, pb};
        nxt_s.rwr = nxt_s.rwr + 12'h001;
      end
    end
    if (commit && nxt_s.rwr != s_ff.rcm) begin
      w = nxt_s.rwr - 12'h001;
      nxt_s.rmem[w[10:0]][8] = 1'b1;
      nxt_s.rcm = nxt_s.rwr;
    end

    // Two-entry output buffer toward the controller
    drain = s_ff.rv && RECV_READY;
    cnt = s_ff.skn - {1'b0, drain};
    if (drain) begin
      nxt_s.sk[0] = s_ff.sk[1];
    end
    take = (s_ff.rrd != s_ff.rcm) && (cnt != 2'd2);
    if (take) begin
      nxt_s.sk[cnt[0]] = s_ff.rmem[s_ff.rrd[10:0]];
      nxt_s.rrd = s_ff.rrd + 12'h001;
    end
    nxt_s.skn = cnt + {1'b0, take};
    nxt_s.rv = (nxt_s.skn != 2'd0);
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_ff <= '0;
      s_ff.tsh <= '1;
      s_ff.r1 <= serial_ptp_pkg::LINE_IDLE;
      s_ff.r2 <= serial_ptp_pkg::LINE_IDLE;
      s_ff.skip <= serial_ptp_pkg::RST_USS_SKIP;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from state flops
  assign SEND_READY = s_ff.sready;
  assign RECV_VALID = s_ff.rv;
  assign RECV_WORD = s_ff.sk[0];
  assign CALL_RETURN_STATUS = s_ff.stat;
  assign LINE_TX = s_ff.tsh[0];
  assign LINE_TX_OE = s_ff.tbusy;

endmodule : serial_ptp_protocol_framer
`default_nettype wire
